// *** rtl/srx_defs.svh ***
// Register indices, field positions and reset values of the receiver status block
`ifndef SRX_DEFS_SVH
`define SRX_DEFS_SVH

// ----------------------------------------
// Register word indices (byte address = 4 x index)
// ----------------------------------------
`define SRX_IDX_LOCK 16'hF600
`define SRX_IDX_DECODE 16'hF602
`define SRX_IDX_CODE 16'hF603
`define SRX_IDX_RESTART 16'hF604
`define SRX_IDX_LOL 16'hF605
`define SRX_IDX_AUX 16'hF608
`define SRX_IDX_IRQ_STAT 16'hF610
`define SRX_IDX_IRQ_MASK 16'hF611

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SRX_DEC_TYPE 0
`define SRX_DEC_KIND 1
`define SRX_AUX_CLK 4
`define SRX_EV_LOST 0
`define SRX_EV_GAIN 1

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SRX_RST_CODE 16'h0000
`define SRX_RST_AUX 4'h0
`define SRX_RST_MASK 2'h0

`endif

// *** rtl/srx_pkg.sv ***
// Types shared by the receiver status and auxiliary output block
package srx_pkg;

   // ----------------------------------------
   // Decoder side inputs
   // ----------------------------------------
   typedef struct packed {
      logic lock;
      logic frame;
      logic [23:0] left;
      logic [23:0] right;
      logic [3:0] pvuc_l;
      logic [3:0] pvuc_r;
      logic compressed;
      logic kind;
      logic [15:0] code;
      logic block_start;
   } srx_rx_t;

   // ----------------------------------------
   // One captured sample and its side bits
   // ----------------------------------------
   typedef struct packed {
      logic [23:0] left;
      logic [23:0] right;
      logic [3:0] pvuc_l;
      logic [3:0] pvuc_r;
      logic kind;
      logic atype;
      logic blk;
   } srx_snap_t;

   typedef enum logic {
      SRX_PLAY = 1'b0,
      SRX_MUTED = 1'b1
   } srx_mute_t;

endpackage

// *** rtl/srx_status_aux.sv ***
// Receiver status, mute/restart control and eight-slot auxiliary TDM output
//
// Behaviour
// - Decode bit reads 0 for linear PCM, 1 for compressed; resets 0.
// - Compressed streams show their 16-bit compression code; reset zero.
// - Losing lock mutes the audio output automatically.
// - Restart control at 0 keeps mute after relock; software toggles 0-1-0.
// - Restart control at 1 resumes audio on relock and clears sticky flag.
// - Sticky flag sets on lock loss after lock; clears on restart write 1.
// - Selected serial output carries eight-slot TDM of audio and side bits.
// - Slot 0: 24 left audio bits, then eight zeros.
// - Slot 1: 20 zeros, left parity, validity, user, status, eight zeros.
// - Slot 2: 22 zeros, compression kind bit, audio type bit, eight zeros.
// - Slots 3 and 6 carry 32 zeros.
// - Slot 4: 24 right audio bits, then eight zeros.
// - Slot 5: 20 zeros, right parity, validity, user, status, eight zeros.
// - Slot 7: 23 zeros, block start bit, eight zeros.
// - Lock flag reads 1 while locked to a valid stream, else 0.
// - Select field is one-hot, ports 0 to 3; port must be master.
//
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/1ps
`include "srx_defs.svh"

module srx_status_aux
   import srx_pkg::*;
(
   // Clock, reset, enable
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [17:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Decoder side
   input wire srx_rx_t rx_i,
   // Serial port side
   input wire logic bit_en_i,
   input wire logic fsync_i,
   input wire logic [3:0] normal_sdata_i,
   output logic [3:0] serial_data_output_o,
   output logic aux_clk_src_o,
   // Audio out and interrupt
   output logic [23:0] audio_l_o,
   output logic [23:0] audio_r_o,
   output logic audio_valid_o,
   output logic irq_o
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic ack;
      logic [31:0] dat;
      logic lock_q;
      logic ever;
      srx_mute_t mute;
      logic lol;
      logic restart;
      logic [3:0] aux_sel;
      logic aux_clk;
      logic [15:0] code;
      srx_snap_t cur;
      srx_snap_t snap;
      logic run;
      logic [2:0] slot;
      logic [4:0] bitn;
      logic [3:0] sdo;
      logic [1:0] ist;
      logic [1:0] imask;
      logic irq;
      logic [23:0] aud_l;
      logic [23:0] aud_r;
      logic aud_v;
   } srx_state_t;

   srx_state_t st;
   srx_state_t next_st;

   // ----------------------------------------
   // Slot contents
   // ----------------------------------------
   function automatic logic [31:0] slot_word(
      input logic [2:0] s,
      input srx_snap_t f
   );
      unique case (s)
         3'h0: slot_word = {f.left, 8'h00};
         3'h1: slot_word = {20'h00000, f.pvuc_l, 8'h00};
         3'h2: slot_word = {22'h000000, f.kind, f.atype, 8'h00};
         3'h3: slot_word = 32'h00000000;
         3'h4: slot_word = {f.right, 8'h00};
         3'h5: slot_word = {20'h00000, f.pvuc_r, 8'h00};
         3'h6: slot_word = 32'h00000000;
         3'h7: slot_word = {23'h000000, f.blk, 8'h00};
      endcase
   endfunction

   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   logic req;
   logic wr;
   logic [15:0] idx;
   logic wr_restart;
   logic lost;
   logic relock;
   logic clr_lol;
   logic toggle_done;
   logic onehot_sel;
   logic tbit;
   logic [3:0] route;
   logic [1:0] ev;
   logic [31:0] word_first;
   logic [31:0] word_run;

   assign req = cyc_i & stb_i & ~st.ack;
   assign wr = req & we_i & sel_i[0];
   assign idx = adr_i[17:2];
   assign wr_restart = wr & (idx == `SRX_IDX_RESTART);

   // ----------------------------------------
   // Lock events
   // ----------------------------------------
   // Loss only counts once a lock was ever held
   assign lost = st.lock_q & ~rx_i.lock & st.ever;
   assign relock = ~st.lock_q & rx_i.lock;
   assign toggle_done = wr_restart & ~dat_i[0] & st.restart;
   assign clr_lol = (wr_restart & dat_i[0]) | (st.restart & relock);
   assign ev = {relock, lost};

   // ----------------------------------------
   // TDM bit source and routing
   // ----------------------------------------
   // Non one-hot selections route nowhere rather than to several ports
   assign onehot_sel = $onehot(st.aux_sel);
   // Fresh sample feeds the first bit; the frozen snapshot feeds the rest
   assign word_first = slot_word(3'h0, st.cur);
   assign word_run = slot_word(st.slot, st.snap);

   always_comb begin
      if (fsync_i) begin
         tbit = word_first[31];
      end else if (st.run) begin
         tbit = word_run[~st.bitn];
      end else begin
         tbit = 1'b0;
      end
   end

   for (genvar k = 0; k < 4; k++) begin : g_route
      always_comb begin
         if (onehot_sel && st.aux_sel[k]) begin
            route[k] = bit_en_i ? tbit : st.sdo[k];
         end else begin
            route[k] = normal_sdata_i[k];
         end
      end
   end

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      next_st = st;
      next_st.ack = req;
      next_st.lock_q = rx_i.lock;
      next_st.ever = st.ever | rx_i.lock;
      next_st.aud_v = 1'b0;
      next_st.sdo = route;

      // Read data
      if (req) begin
         unique case (idx)
            `SRX_IDX_LOCK: next_st.dat = {31'h0, st.lock_q};
            `SRX_IDX_DECODE: next_st.dat = {30'h0, st.cur.kind, st.cur.atype};
            `SRX_IDX_CODE: next_st.dat = {16'h0000, st.code};
            `SRX_IDX_RESTART: next_st.dat = {31'h0, st.restart};
            `SRX_IDX_LOL: next_st.dat = {31'h0, st.lol};
            `SRX_IDX_AUX: next_st.dat = {27'h0, st.aux_clk, st.aux_sel};
            `SRX_IDX_IRQ_STAT: next_st.dat = {30'h0, st.ist};
            `SRX_IDX_IRQ_MASK: next_st.dat = {30'h0, st.imask};
            default: next_st.dat = 32'h00000000;
         endcase
      end

      // Writes
      if (wr_restart) begin
         next_st.restart = dat_i[0];
      end
      if (wr && idx == `SRX_IDX_AUX) begin
         next_st.aux_sel = dat_i[3:0];
         next_st.aux_clk = dat_i[`SRX_AUX_CLK];
      end
      if (wr && idx == `SRX_IDX_IRQ_MASK) begin
         next_st.imask = dat_i[1:0];
      end

      // Interrupt status: a new event beats a same-cycle clear
      if (wr && idx == `SRX_IDX_IRQ_STAT) begin
         next_st.ist = (st.ist & ~dat_i[1:0]) | ev;
      end else begin
         next_st.ist = st.ist | ev;
      end
      next_st.irq = |(next_st.ist & st.imask);

      // Sticky loss flag, set wins
      next_st.lol = lost | (st.lol & ~clr_lol);

      // Mute control
      if (lost) begin
         next_st.mute = SRX_MUTED;
      end else if (st.mute == SRX_MUTED && rx_i.lock) begin
         if ((st.restart && relock) || toggle_done) begin
            next_st.mute = SRX_PLAY;
         end
      end

      // Decoded sample capture
      if (rx_i.frame) begin
         next_st.cur.left = rx_i.left;
         next_st.cur.right = rx_i.right;
         next_st.cur.pvuc_l = rx_i.pvuc_l;
         next_st.cur.pvuc_r = rx_i.pvuc_r;
         next_st.cur.kind = rx_i.kind;
         next_st.cur.atype = rx_i.compressed;
         next_st.cur.blk = rx_i.block_start;
         if (rx_i.compressed) begin
            next_st.code = rx_i.code;
         end
      end

      // Audio output, silent while muted or unlocked
      if (rx_i.frame && rx_i.lock && st.mute == SRX_PLAY && !lost) begin
         next_st.aud_l = rx_i.left;
         next_st.aud_r = rx_i.right;
         next_st.aud_v = 1'b1;
      end else if (st.mute == SRX_MUTED || lost) begin
         next_st.aud_l = 24'h000000;
         next_st.aud_r = 24'h000000;
      end

      // TDM counters point at the next bit to emit
      if (bit_en_i) begin
         if (fsync_i) begin
            next_st.snap = st.cur;
            next_st.run = 1'b1;
            next_st.slot = 3'h0;
            next_st.bitn = 5'h01;
         end else if (st.run) begin
            {next_st.slot, next_st.bitn} = {st.slot, st.bitn} + 8'h01;
         end
      end
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st <= '0;
         st.code <= `SRX_RST_CODE;
         st.aux_sel <= `SRX_RST_AUX;
         st.imask <= `SRX_RST_MASK;
         st.mute <= SRX_PLAY;
      end else if (ce_i) begin
         st <= next_st;
      end
   end

   assign dat_o = st.dat;
   assign ack_o = st.ack;
   assign serial_data_output_o = st.sdo;
   assign aux_clk_src_o = st.aux_clk;
   assign audio_l_o = st.aud_l;
   assign audio_r_o = st.aud_r;
   assign audio_valid_o = st.aud_v;
   assign irq_o = st.irq;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   mute_on_loss_a: assert property (
      ce_i && lost |=> st.mute == SRX_MUTED && !audio_valid_o
   ) else $error("no mute after lock loss");

   manual_hold_a: assert property (
      ce_i && st.mute == SRX_MUTED && !st.restart && !toggle_done && !wr_restart
      |=> st.mute == SRX_MUTED
   ) else $error("mute left without restart");

   auto_resume_a: assert property (
      ce_i && st.restart && relock && !lost |=> st.mute == SRX_PLAY && !st.lol
   ) else $error("no auto resume on relock");

   sticky_set_a: assert property (
      ce_i && lost |=> st.lol ##1 (st.lol || $past(clr_lol) || !$past(ce_i))
   ) else $error("sticky flag not held");

   type_bit_a: assert property (
      ce_i && rx_i.frame |=> st.cur.atype == $past(rx_i.compressed)
   ) else $error("audio type bit wrong");

   code_keep_a: assert property (
      ce_i && rx_i.frame && !rx_i.compressed |=> st.code == $past(st.code)
   ) else $error("code changed on pcm");

   lock_flag_a: assert property (
      ce_i |=> st.lock_q == $past(rx_i.lock)
   ) else $error("lock flag stale");

   zero_slot_a: assert property (
      ce_i && bit_en_i && !fsync_i && st.run && onehot_sel
      && (st.slot == 3'h3 || st.slot == 3'h6)
      |=> (serial_data_output_o & $past(st.aux_sel)) == 4'h0
   ) else $error("zero slot not zero");

   idle_route_a: assert property (
      !rst_i && ce_i && st.aux_sel == 4'h0 |=> serial_data_output_o == $past(normal_sdata_i)
   ) else $error("normal data disturbed");

   ack_pulse_a: assert property (
      ce_i && ack_o |=> !ack_o
   ) else $error("ack longer than one cycle");

   ack_answer_a: assert property (
      ce_i && req |=> ack_o
   ) else $error("request not acknowledged");

   irq_level_a: assert property (
      ce_i && |(st.ist & st.imask) && !(wr && idx == `SRX_IDX_IRQ_STAT)
      |=> irq_o
   ) else $error("interrupt not raised");

   lost_event_a: assert property (
      ce_i && lost |=> st.ist[`SRX_EV_LOST]
   ) else $error("loss event not recorded");

   relock_event_a: assert property (
      ce_i && relock |=> st.ist[`SRX_EV_GAIN]
   ) else $error("relock event not recorded");

   first_bit_a: assert property (
      ce_i && bit_en_i && fsync_i && onehot_sel
      |=> (serial_data_output_o & $past(st.aux_sel))
         == ($past(st.cur.left[23]) ? $past(st.aux_sel) : 4'h0)
   ) else $error("first frame bit wrong");

   block_bit_a: assert property (
      ce_i && bit_en_i && !fsync_i && st.run && onehot_sel
      && st.slot == 3'h7 && st.bitn == 5'h17
      |=> (serial_data_output_o & $past(st.aux_sel))
         == ($past(st.snap.blk) ? $past(st.aux_sel) : 4'h0)
   ) else $error("block start bit wrong");

   ce_freeze_a: assert property (
      !rst_i && !ce_i |=> $stable(st)
   ) else $error("state moved while disabled");

   code_capture_a: assert property (
      ce_i && rx_i.frame && rx_i.compressed |=> st.code == $past(rx_i.code)
   ) else $error("compression code not captured");

   audio_zero_a: assert property (
      ce_i && st.mute == SRX_MUTED
      |=> audio_l_o == 24'h000000 && audio_r_o == 24'h000000
   ) else $error("audio not silent while muted");

endmodule // srx_status_aux

// *** verification/srx_far_model.sv ***
// Far-side model: decoder feed to the block and eight-slot TDM capture
`timescale 1ns/1ps

module srx_far_model
   import srx_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Stream content and capture control
   input wire logic lock_i,
   input wire srx_rx_t data_i,
   input wire logic [1:0] port_i,
   input wire logic [3:0] sdo_i,
   // Towards block and bench
   output srx_rx_t rx_o,
   output logic bit_en_o,
   output logic fsync_o,
   output logic [255:0] cap_o
);
   logic [5:0] fcnt;
   logic [7:0] bcnt;
   logic [255:0] sh;

   always_comb begin
      rx_o = data_i;
      rx_o.lock = lock_i;
      rx_o.frame = (fcnt == 6'h00);
      fsync_o = bit_en_o && (bcnt == 8'h00);
   end

   // Bit seen at a bit_en edge is the one launched at the edge before
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fcnt <= 6'h00;
         bcnt <= 8'h00;
         bit_en_o <= 1'b0;
         sh <= '0;
         cap_o <= '0;
      end else begin
         fcnt <= fcnt + 6'h01;
         bit_en_o <= ~bit_en_o;
         if (bit_en_o) begin
            bcnt <= bcnt + 8'h01;
            sh <= {sh[254:0], sdo_i[port_i]};
            if (fsync_o) begin
               cap_o <= {sh[254:0], sdo_i[port_i]};
            end
         end
      end
   end
endmodule // srx_far_model

// *** verification/srx_status_aux_test.sv ***
// Self-checking bench of the receiver status and auxiliary TDM block
`timescale 1ns/1ps
`include "srx_defs.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_total++; \
   $display("[ERR] t=%0t got=%0h exp=%0h", $time, (a), (b)); end end

module srx_status_aux_test
   import srx_pkg::*;
;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic ce = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic lock = 1'b0;
   logic [17:0] adr = '0;
   logic [3:0] sel = 4'h0;
   logic [31:0] dat = '0;
   logic [3:0] nd = 4'hF;
   logic [1:0] port = 2'h0;
   srx_rx_t src;
   srx_rx_t rx;
   logic [31:0] rd, dat_o;
   logic ack, bit_en, fsync, aux_clk, aval, irq;
   logic [3:0] sdo;
   logic [23:0] audl, audr;
   logic [255:0] cap;
   int err_total = 0;
   int n_checks = 0;
   int nvalid = 0;
   int n;

   srx_status_aux dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .cyc_i(cyc), .stb_i(stb),
      .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack),
      .rx_i(rx), .bit_en_i(bit_en), .fsync_i(fsync), .normal_sdata_i(nd),
      .serial_data_output_o(sdo), .aux_clk_src_o(aux_clk), .audio_l_o(audl),
      .audio_r_o(audr), .audio_valid_o(aval), .irq_o(irq));
   srx_far_model far (.clk_i(clk_i), .rst_i(rst_i), .lock_i(lock), .data_i(src),
      .port_i(port), .sdo_i(sdo), .rx_o(rx), .bit_en_o(bit_en), .fsync_o(fsync), .cap_o(cap));

   always #20 clk_i = ~clk_i;
   always @(posedge clk_i) if (aval === 1'b1) nvalid++;

   // ----------------------------------------
   // Bus and helper tasks
   // ----------------------------------------
   task stop_test;
      $display("checks=%0d errors=%0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   task wb(input logic w, input logic [15:0] idx, input logic [31:0] d);
      int k;
      @(posedge clk_i);
      {cyc, stb, we, adr, dat, sel} <= {2'b11, w, idx, 2'b00, d, 4'hF};
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (ack !== 1'b1 && k < 20);
      rd = dat_o;
      {cyc, stb} <= 2'b00;
      if (k >= 20) begin
         err_total++;
         stop_test();
      end
   endtask

   task rchk(input logic [15:0] idx, input logic [31:0] e);
      wb(1'b0, idx, 32'h0);
      `CHK(rd, e)
   endtask

   task setlk(input logic v);
      @(posedge clk_i);
      lock <= v;
   endtask

   function automatic logic [255:0] frame_of(srx_rx_t d);
      return {d.left, 8'h00, 20'h0, d.pvuc_l, 8'h00, 22'h0, d.kind, d.compressed, 8'h00,
         32'h0, d.right, 8'h00, 20'h0, d.pvuc_r, 8'h00, 32'h0, 23'h0, d.block_start, 8'h00};
   endfunction

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task t_reset;
      rchk(`SRX_IDX_DECODE, 32'h0);
      rchk(`SRX_IDX_CODE, 32'h0);
      rchk(`SRX_IDX_LOL, 32'h0);
      rchk(`SRX_IDX_AUX, 32'h0);
      rchk(`SRX_IDX_LOCK, 32'h0);
      wb(1'b1, 16'h0100, 32'hFFFF);
      rchk(16'h0100, 32'h0);
   endtask

   task t_decode;
      @(posedge clk_i);
      src.compressed <= 1'b1;
      src.kind <= 1'b1;
      lock <= 1'b1;
      repeat (200) @(posedge clk_i);
      rchk(`SRX_IDX_DECODE, 32'h3);
      rchk(`SRX_IDX_CODE, 32'h1234);
      rchk(`SRX_IDX_LOCK, 32'h1);
   endtask

   // No auto restart: stay muted until the 0-1-0 toggle
   task t_manual;
      wb(1'b1, `SRX_IDX_RESTART, 32'h0);
      wb(1'b1, `SRX_IDX_IRQ_MASK, 32'h1);
      setlk(1'b0);
      repeat (3) @(posedge clk_i);
      `CHK(irq, 1'b1)
      rchk(`SRX_IDX_LOL, 32'h1);
      n = nvalid;
      setlk(1'b1);
      repeat (200) @(posedge clk_i);
      `CHK(nvalid, n)
      wb(1'b1, `SRX_IDX_RESTART, 32'h1);
      rchk(`SRX_IDX_LOL, 32'h0);
      wb(1'b1, `SRX_IDX_RESTART, 32'h0);
      repeat (200) @(posedge clk_i);
      `CHK(nvalid > n, 1'b1)
      wb(1'b1, `SRX_IDX_IRQ_STAT, 32'h3);
      repeat (2) @(posedge clk_i);
      `CHK(irq, 1'b0)
   endtask

   task t_auto;
      wb(1'b1, `SRX_IDX_RESTART, 32'h1);
      setlk(1'b0);
      repeat (3) @(posedge clk_i);
      rchk(`SRX_IDX_LOL, 32'h1);
      n = nvalid;
      repeat (100) @(posedge clk_i);
      `CHK(nvalid, n)
      setlk(1'b1);
      repeat (3) @(posedge clk_i);
      rchk(`SRX_IDX_LOL, 32'h0);
      repeat (200) @(posedge clk_i);
      `CHK(nvalid > n, 1'b1)
      `CHK({audl, audr}, {src.left, src.right})
   endtask

   task t_tdm;
      for (int p = 0; p < 4; p++) begin
         wb(1'b1, `SRX_IDX_AUX, 32'h10 | (32'h1 << p));
         port <= p[1:0];
         repeat (1100) @(posedge clk_i);
         `CHK(cap, frame_of(src))
         `CHK(sdo | (4'h1 << p), 4'hF)
         `CHK(aux_clk, 1'b1)
      end
   endtask

   // A lock drop hidden by a held clock enable must leave no trace
   task t_freeze;
      wb(1'b1, `SRX_IDX_RESTART, 32'h0);
      @(posedge clk_i);
      ce <= 1'b0;
      lock <= 1'b0;
      repeat (10) @(posedge clk_i);
      ce <= 1'b1;
      lock <= 1'b1;
      repeat (3) @(posedge clk_i);
      rchk(`SRX_IDX_LOL, 32'h0);
      rchk(`SRX_IDX_LOCK, 32'h1);
      n = nvalid;
      repeat (200) @(posedge clk_i);
      `CHK(nvalid > n, 1'b1)
   endtask

   task t_pass;
      wb(1'b1, `SRX_IDX_AUX, 32'h0);
      nd <= 4'h9;
      repeat (3) @(posedge clk_i);
      `CHK(sdo, 4'h9)
      wb(1'b1, `SRX_IDX_AUX, 32'h3);
      nd <= 4'h6;
      repeat (3) @(posedge clk_i);
      `CHK(sdo, 4'h6)
   endtask

   initial begin
      src = '0;
      src.left = 24'hA5C3F1;
      src.right = 24'h3C5A96;
      src.pvuc_l = 4'hA;
      src.pvuc_r = 4'h5;
      src.code = 16'h1234;
      src.block_start = 1'b1;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_decode();
      t_manual();
      t_auto();
      t_tdm();
      t_freeze();
      t_pass();
      stop_test();
   end

   // Run needs about 5600 cycles
   initial begin
      #800000;
      err_total++;
      stop_test();
   end
endmodule // srx_status_aux_test
